// ===== logic/lsrm_map.vh
// How it works
// R1: Clock select low runs the internal oscillator and drives it out on the clock pin.
// R2: Clock select high makes the clock pin an input that times everything.
// R3: Host should supply above 125 kHz device clock for full 100 kHz bus rate.
// R4: The system must keep the device clock running at all times.
// R5: Frame is device clock over 2880 normally, over 480 in power-saving mode.
// R6: A byte arriving before the last is stored stalls the host, losing nothing; the core buffers two bytes and stalls only when both entries are full.
// R7: The shared cascade sync line keeps frame timing aligned across drivers.
// R8: Next RAM column shifts in while the latch is shown for a whole slot.
// R9: Forty segment outputs combine latch bits with the active backplane timing.
// R10: In three-backplane mode backplane three copies backplane one.
// R11: In two-backplane mode zero equals two and one equals three.
// R12: In static mode all four backplanes carry one waveform.
// R13: Display memory is 40 words of 4 bits; a one lights its segment.
// R14: Address n drives segment n; word bit n shows in backplane n slot.
// R15: Static mode writes eight bits into bit 0 of eight addresses.
// R16: Two-backplane mode writes bits 0 and 1 of four addresses.
// R17: Three-backplane mode fills three addresses, leaving bit 2 of the third.
// R18: Four-backplane mode writes bits 0 to 3 of two addresses.
// R19: Pointer load sets the data pointer where following bytes start.
// R20: Pointer advances eight, four, three or two per byte by mode.
// R21: Writes happen only when subaddress counter equals the pins; pointer always advances.
// R22: Pointer overflow past the last address increments the subaddress counter.
// R23: Three-backplane mode advances the pointer by three per byte.
// R24: Reset clears pointer and subaddress counter, selects four backplanes, one-third bias.
// R25: Latch loads bit 0 of all addresses first, then bits 1, 2 and 3.
`ifndef LSRM_MAP_VH
`define LSRM_MAP_VH
`define LSRM_NSEG 40
`define LSRM_LAST_ADDR 6'h27
`define LSRM_MODE_STATIC 2'h0
`define LSRM_MODE_MUX2 2'h1
`define LSRM_MODE_MUX3 2'h2
`define LSRM_MODE_MUX4 2'h3
`define LSRM_RST_MODE 2'h3
`define LSRM_RST_BIAS_THIRD 1'h1
`define LSRM_FRAME_DIV_NORM 2880
`define LSRM_FRAME_DIV_PS 480
`define LSRM_SYS_PERIOD_NS 4
`define LSRM_OSC_PERIOD_NS 5425
`define LSRM_OSC_CYC (`LSRM_OSC_PERIOD_NS / `LSRM_SYS_PERIOD_NS)
`endif

// ===== logic/lsrm_core.v
`timescale 1ns/1ps
`include "lsrm_map.vh"
module lsrm_core #(
	parameter OSC_DIV = `LSRM_OSC_CYC
) (
	// Clock, reset and clock enable.
	input wire sys_clk_i,
	input wire nrst_i,
	input wire ce_i,
	// Clock source pins.
	input wire osc_sel_i,
	input wire clk_pin_i,
	output reg clk_pin_o,
	output reg clk_pin_oe_n_o,
	// Cascade sync pin, open drain, active low.
	input wire sync_pin_i,
	output reg sync_pin_o,
	output reg sync_pin_oe_n_o,
	// Configuration.
	input wire pwr_save_i,
	input wire mode_set_i,
	input wire [1:0] mode_i,
	input wire bias_third_i,
	output reg bias_third_o,
	// Commands.
	input wire ptr_load_i,
	input wire [5:0] ptr_i,
	input wire dev_sel_i,
	input wire [2:0] dev_i,
	input wire [2:0] hw_subaddress_pins_i,
	// Display byte stream.
	input wire data_valid_i,
	input wire [7:0] data_i,
	output reg data_ready_o,
	output reg scl_hold_o,
	// Status.
	output reg [5:0] ptr_o,
	output reg [2:0] subaddr_o,
	// LCD drive.
	output reg [39:0] segment_outputs_o,
	output reg backplane_zero_o,
	output reg backplane_one_o,
	output reg backplane_two_o,
	output reg backplane_three_o
);
	localparam ST_IDLE = 1'b0;
	localparam ST_WRITE = 1'b1;

	// Slot length in device ticks for a mode.
	function [11:0] slot_len;
		input [1:0] m;
		input ps;
		integer full;
		begin
			case (m)
				`LSRM_MODE_STATIC: full = ps ? `LSRM_FRAME_DIV_PS : `LSRM_FRAME_DIV_NORM;
				`LSRM_MODE_MUX2: full = ps ? `LSRM_FRAME_DIV_PS / 2 : `LSRM_FRAME_DIV_NORM / 2;
				`LSRM_MODE_MUX3: full = ps ? `LSRM_FRAME_DIV_PS / 3 : `LSRM_FRAME_DIV_NORM / 3;
				default: full = ps ? `LSRM_FRAME_DIV_PS / 4 : `LSRM_FRAME_DIV_NORM / 4;
			endcase
			slot_len = full[11:0];
		end
	endfunction

	// Slot in which a backplane output is active.
	function [1:0] bp_slot;
		input [1:0] m;
		input [1:0] idx;
		begin
			case (m)
				`LSRM_MODE_STATIC: bp_slot = 2'h0; // R12
				`LSRM_MODE_MUX2: bp_slot = {1'b0, idx[0]}; // R11
				`LSRM_MODE_MUX3: bp_slot = (idx == 2'h3) ? 2'h1 : idx; // R10
				default: bp_slot = idx;
			endcase
		end
	endfunction

	// Pin synchronisers.
	reg [1:0] osc_sel_s;
	reg [2:0] clk_s;
	reg [1:0] sync_s;
	reg [2:0] hw_a_s0;
	reg [2:0] hw_a_s1;
	always @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			osc_sel_s <= 2'h0;
			clk_s <= 3'h0;
			sync_s <= 2'h3;
			hw_a_s0 <= 3'h0;
			hw_a_s1 <= 3'h0;
		end else if (ce_i) begin
			osc_sel_s <= {osc_sel_s[0], osc_sel_i};
			clk_s <= {clk_s[1:0], clk_pin_i};
			sync_s <= {sync_s[0], sync_pin_i};
			hw_a_s0 <= hw_subaddress_pins_i;
			hw_a_s1 <= hw_a_s0;
		end
	end

	// Internal oscillator and device clock tick.
	reg [11:0] osc_cnt;
	wire osc_tick = (osc_cnt == OSC_DIV - 1);
	wire ext_tick = clk_s[1] & ~clk_s[2];
	wire tick = osc_sel_s[1] ? ext_tick : osc_tick; // R1 R2
	always @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			osc_cnt <= 12'h000;
			clk_pin_o <= 1'b0;
			clk_pin_oe_n_o <= 1'b1;
		end else if (ce_i) begin
			osc_cnt <= osc_tick ? 12'h000 : osc_cnt + 12'h001;
			clk_pin_o <= (osc_cnt < OSC_DIV / 2);
			clk_pin_oe_n_o <= osc_sel_s[1]; // R1 R2
		end
	end

	// Mode and bias.
	reg [1:0] mode;
	always @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			mode <= `LSRM_RST_MODE; // R24
			bias_third_o <= `LSRM_RST_BIAS_THIRD; // R24
		end else if (ce_i && mode_set_i) begin
			mode <= mode_i;
			bias_third_o <= bias_third_i;
		end
	end

	// Two-entry input buffer.
	reg [7:0] buf0;
	reg [7:0] buf1;
	reg [1:0] buf_cnt;
	reg wstate;
	wire push = data_valid_i & data_ready_o;
	wire pop = (buf_cnt != 2'h0) & (wstate == ST_IDLE);
	reg [1:0] next_buf_cnt;
	always @* begin
		next_buf_cnt = buf_cnt;
		if (push & ~pop)
			next_buf_cnt = buf_cnt + 2'h1;
		else if (pop & ~push)
			next_buf_cnt = buf_cnt - 2'h1;
	end
	always @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			buf0 <= 8'h00;
			buf1 <= 8'h00;
			buf_cnt <= 2'h0;
			data_ready_o <= 1'b0;
			scl_hold_o <= 1'b0;
		end else if (ce_i) begin
			buf_cnt <= next_buf_cnt;
			data_ready_o <= (next_buf_cnt != 2'h2);
			scl_hold_o <= (next_buf_cnt == 2'h2); // R6
			if (pop)
				buf0 <= (buf_cnt == 2'h2) ? buf1 : data_i;
			if (push) begin
				if (pop ? (buf_cnt == 2'h2) : (buf_cnt == 2'h1))
					buf1 <= data_i;
				else if (!pop && buf_cnt == 2'h0)
					buf0 <= data_i;
			end
		end
	end

	// Byte writer with display RAM.
	reg [3:0] ram [0:`LSRM_NSEG-1]; // R13
	reg [7:0] wbyte;
	reg [3:0] wleft;
	reg [3:0] next_ram_word;
	wire [3:0] per_addr = {2'h0, mode} + 4'h1;
	wire [3:0] k = (wleft < per_addr) ? wleft : per_addr;
	wire wr_en = (subaddr_o == hw_a_s1); // R21
	wire wrap = (ptr_o >= `LSRM_LAST_ADDR);
	integer i;
	integer j;
	// New contents of the addressed word, MSB of the byte first.
	always @* begin
		next_ram_word = ram[ptr_o];
		for (j = 0; j < 4; j = j + 1)
			if (j < k)
				next_ram_word[j] = wbyte[7-j]; // R15 R16 R17 R18
	end
	always @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			wstate <= ST_IDLE;
			wbyte <= 8'h00;
			wleft <= 4'h0;
			ptr_o <= 6'h00; // R24
			subaddr_o <= 3'h0; // R24
			for (i = 0; i < `LSRM_NSEG; i = i + 1)
				ram[i] <= 4'h0;
		end else if (ce_i) begin
			if (ptr_load_i)
				ptr_o <= ptr_i; // R19
			if (dev_sel_i)
				subaddr_o <= dev_i; // R21
			case (wstate)
				ST_IDLE: begin
					if (pop) begin
						wbyte <= (buf_cnt == 2'h0) ? data_i : buf0;
						wleft <= 4'h8;
						wstate <= ST_WRITE;
					end
				end
				ST_WRITE: begin
					if (tick && !ptr_load_i && !dev_sel_i) begin
						if (wr_en)
							ram[ptr_o] <= next_ram_word;
						wbyte <= wbyte << k;
						wleft <= wleft - k;
						ptr_o <= wrap ? 6'h00 : ptr_o + 6'h01; // R20 R23
						if (wrap)
							subaddr_o <= subaddr_o + 3'h1; // R22
						if (wleft == k)
							wstate <= ST_IDLE;
					end
				end
				default: wstate <= ST_IDLE;
			endcase
		end
	end

	// Multiplex timing, shift register and display latch.
	reg [11:0] tcnt;
	reg [1:0] slot;
	reg phase;
	reg [5:0] sh_addr;
	reg [39:0] shreg;
	reg [39:0] latch;
	reg [2:0] own_drv;
	wire [1:0] nslot = (slot == mode) ? 2'h0 : slot + 2'h1;
	wire slot_end = (tcnt == slot_len(mode, pwr_save_i) - 12'h001); // R5
	wire frame_end = slot_end & (slot == mode);
	wire ext_sync = ~sync_s[1] & ~(|own_drv);
	always @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			tcnt <= 12'h000;
			slot <= 2'h0;
			phase <= 1'b0;
			sh_addr <= 6'h00;
			shreg <= 40'h0;
			latch <= 40'h0;
			own_drv <= 3'h0;
			sync_pin_o <= 1'b0;
			sync_pin_oe_n_o <= 1'b1;
		end else if (ce_i) begin
			own_drv <= {own_drv[1:0], ~sync_pin_oe_n_o};
			if (mode_set_i || ext_sync) begin // R7
				tcnt <= 12'h000;
				slot <= 2'h0;
				sh_addr <= 6'h00;
			end else if (tick) begin
				sync_pin_oe_n_o <= ~frame_end; // R7
				if (slot_end) begin
					tcnt <= 12'h000;
					latch <= shreg; // R8
					sh_addr <= 6'h00;
					slot <= nslot; // R25
					if (frame_end)
						phase <= ~phase;
				end else begin
					tcnt <= tcnt + 12'h001;
					if (sh_addr <= `LSRM_LAST_ADDR) begin
						shreg <= {ram[sh_addr][nslot], shreg[39:1]}; // R8 R14 R25
						sh_addr <= sh_addr + 6'h01;
					end
				end
			end
		end
	end

	// Drive outputs.
	always @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			segment_outputs_o <= {40{1'b1}};
			backplane_zero_o <= 1'b1;
			backplane_one_o <= 1'b1;
			backplane_two_o <= 1'b1;
			backplane_three_o <= 1'b1;
		end else if (ce_i) begin
			segment_outputs_o <= ~latch ^ {40{phase}}; // R9 R14
			backplane_zero_o <= phase ^ (bp_slot(mode, 2'h0) == slot);
			backplane_one_o <= phase ^ (bp_slot(mode, 2'h1) == slot);
			backplane_two_o <= phase ^ (bp_slot(mode, 2'h2) == slot);
			backplane_three_o <= phase ^ (bp_slot(mode, 2'h3) == slot); // R10 R11 R12
		end
	end
endmodule

// ===== dv/lsrm_properties.sv
`timescale 1ns/1ps
module lsrm_properties (
	// Inputs of the core, and its pointer output ptr_o.
	input wire sys_clk_i, nrst_i, ce_i, osc_sel_i, mode_set_i, ptr_load_i,
	input wire [1:0] mode_i,
	input wire [5:0] ptr_i, ptr_o,
	// Outputs of the core.
	input wire [2:0] subaddr_o,
	input wire clk_pin_oe_n_o, data_ready_o, scl_hold_o, bias_third_o,
	input wire [39:0] segment_outputs_o,
	input wire backplane_zero_o, backplane_one_o, backplane_two_o, backplane_three_o
);
	reg [1:0] md;
	reg [2:0] age;
	always @(posedge sys_clk_i) begin
		if (!nrst_i || (mode_set_i && ce_i)) begin
			md <= nrst_i ? mode_i : 2'h3;
			age <= 3'h0;
		end else if (age != 3'h7) begin
			age <= age + 3'h1;
		end
	end
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!nrst_i);
	sequence s_osc(v);
		(osc_sel_i == v && ce_i) [*6];
	endsequence
	property p_int; s_osc(1'b0) |-> !clk_pin_oe_n_o; endproperty
	a_int: assert property (p_int) else $error("clock pin not driven");
	property p_ext; s_osc(1'b1) |-> clk_pin_oe_n_o; endproperty
	a_ext: assert property (p_ext) else $error("clock pin driven");
	property p_hold; $fell(data_ready_o) |-> scl_hold_o; endproperty
	a_hold: assert property (p_hold) else $error("no clock hold");
	property p_ptr; ptr_load_i && ce_i |=> ptr_o == $past(ptr_i); endproperty
	a_ptr: assert property (p_ptr) else $error("pointer load");
	property p_rst;
		$rose(nrst_i) |-> ptr_o == 6'h00 && subaddr_o == 3'h0 && bias_third_o
			&& !data_ready_o && &segment_outputs_o;
	endproperty
	a_rst: assert property (p_rst) else $error("reset state");
	property p_step;
		ptr_o != $past(ptr_o) && !$past(ptr_load_i) |-> ptr_o == $past(ptr_o) + 6'h1
			|| (ptr_o == 6'h00 && $past(ptr_o) >= 6'h27);
	endproperty
	a_step: assert property (p_step) else $error("pointer step");
	property p_m3; md == 2'h2 && age == 3'h7 |-> backplane_three_o == backplane_one_o; endproperty
	a_m3: assert property (p_m3) else $error("three backplane copy");
	property p_m2;
		md == 2'h1 && age == 3'h7 |-> backplane_zero_o == backplane_two_o
			&& backplane_one_o == backplane_three_o;
	endproperty
	a_m2: assert property (p_m2) else $error("two backplane pairs");
	property p_st;
		md == 2'h0 && age == 3'h7
			|-> {backplane_one_o, backplane_two_o, backplane_three_o} == {3{backplane_zero_o}};
	endproperty
	a_st: assert property (p_st) else $error("static backplanes");
endmodule
bind lsrm_core lsrm_properties lsrm_properties_inst (.*);

// ===== dv/lsrm_host.sv
`timescale 1ns/1ps
module lsrm_host (
	// Clock and handshake.
	input wire logic sys_clk_i,
	input wire logic byte_ready_i,
	input wire logic slow_i,
	output logic byte_valid_o = 1'b0,
	output logic [7:0] byte_o = 8'h00
);
	logic [7:0] q[$];
	int gap = 0;
	task put(input logic [7:0] b);
		q.push_back(b);
	endtask
	always @(posedge sys_clk_i) begin
		if (byte_valid_o && byte_ready_i) begin
			void'(q.pop_front());
			gap = slow_i ? 3 : 0;
		end else if (gap > 0) begin
			gap = gap - 1;
		end
		#1;
		byte_valid_o = q.size() > 0 && gap == 0;
		byte_o = byte_valid_o ? q[0] : ~byte_o;
	end
endmodule

// ===== dv/tb.sv
`timescale 1ns/1ps
module tb;
	logic sys_clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic osc_sel_i = 1'b0;
	logic clk_pin_i = 1'b0;
	logic pwr_save_i = 1'b1;
	logic mode_set_i = 1'b0;
	logic [1:0] mode_i = 2'h3;
	logic bias_third_i = 1'b1;
	logic ptr_load_i = 1'b0;
	logic dev_sel_i = 1'b0;
	logic [5:0] ptr_i = 6'h00;
	logic [2:0] dev_i = 3'h0;
	logic [2:0] hw_subaddress_pins_i = 3'h0;
	logic slow = 1'b0;
	logic held = 1'b0;
	wire data_valid_i, data_ready_o, scl_hold_o, sync_pin_o, sync_pin_oe_n_o, backplane_zero_o;
	wire [7:0] data_i;
	wire [5:0] ptr_o;
	wire [2:0] subaddr_o;
	wire bias_third_o;
	wire [39:0] segment_outputs_o;
	wire sync_line = sync_pin_oe_n_o ? 1'b1 : sync_pin_o;
	int mismatches = 0;
	int n_checks = 0;
	int steps[4] = '{8, 4, 3, 2};
	always #2 sys_clk_i = ~sys_clk_i;
	always #6 clk_pin_i = ~clk_pin_i;
	always @(posedge sys_clk_i) if (scl_hold_o === 1'b1) held <= 1'b1;
	lsrm_core #(.OSC_DIV(4)) lsrm_core_inst (.*, .ce_i(1'b1), .sync_pin_i(sync_line),
		.clk_pin_o(), .clk_pin_oe_n_o(), .bias_third_o(bias_third_o), .backplane_one_o(),
		.backplane_two_o(), .backplane_three_o());
	lsrm_host lsrm_host_inst (.sys_clk_i, .byte_ready_i(data_ready_o), .slow_i(slow),
		.byte_valid_o(data_valid_i), .byte_o(data_i));
	task tick(input int n);
		repeat (n) @(posedge sys_clk_i);
		#1;
	endtask
	task chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task setup(input logic [1:0] m, input logic [5:0] p, input logic [2:0] d);
		mode_i = m;
		ptr_i = p;
		dev_i = d;
		mode_set_i = 1'b1;
		tick(1);
		mode_set_i = 1'b0;
		ptr_load_i = 1'b1;
		dev_sel_i = 1'b1;
		tick(1);
		ptr_load_i = 1'b0;
		dev_sel_i = 1'b0;
		chk(ptr_o, p);
		chk(subaddr_o, d);
	endtask
	task send(input logic [7:0] b, input int n, input logic [5:0] exp);
		repeat (n) lsrm_host_inst.put(b);
		for (int i = 0; i < 3000 && ptr_o !== exp; i++) tick(1);
		tick(40);
		chk(ptr_o, exp);
	endtask
	task end_of_test();
		$display("checks %0d, mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		#200000;
		mismatches++;
		end_of_test();
	end
	initial begin
		tick(6);
		nrst_i = 1'b1;
		tick(1);
		chk(ptr_o, 6'h00);
		setup(2'h0, 6'h00, 3'h0);
		send(8'hf0, 1, 6'h08);
		tick(6000);
		chk(segment_outputs_o[7:0] ^ {8{backplane_zero_o}}, 8'h0f);
		for (int m = 1; m < 4; m++) begin
			setup(2'(m), 6'h04, 3'h0);
			send(8'h5a, 1, 6'(4 + steps[m]));
		end
		setup(2'h3, 6'h00, 3'h0);
		send(8'h3c, 6, 6'h0c);
		chk(held, 1'b1);
		slow = 1'b1;
		send(8'h81, 3, 6'h12);
		setup(2'h3, 6'h10, 3'h2);
		send(8'hff, 1, 6'h12);
		chk(subaddr_o, 3'h2);
		setup(2'h3, 6'h26, 3'h0);
		send(8'h0f, 1, 6'h00);
		chk(subaddr_o, 3'h1);
		osc_sel_i = 1'b1;
		bias_third_i = 1'b0;
		hw_subaddress_pins_i = 3'h5;
		setup(2'h3, 6'h00, 3'h5);
		send(8'h77, 2, 6'h04);
		nrst_i = 1'b0;
		tick(2);
		nrst_i = 1'b1;
		tick(1);
		chk(ptr_o, 6'h00);
		chk(subaddr_o, 3'h0);
		chk(bias_third_o, 1'b1);
		end_of_test();
	end
endmodule
